// ### rtl/hsc_pkg.sv
package hsc_pkg;

  // bus identity and command codes
  localparam logic [6:0]  TARGET_ADDR         = 7'h70;
  localparam logic [15:0] CMD_MEAS_STR_TEMP   = 16'h7CA2;
  localparam logic [15:0] CMD_MEAS_STR_HUM    = 16'h5C24;
  localparam logic [15:0] CMD_MEAS_FREE_TEMP  = 16'h7866;
  localparam logic [15:0] CMD_MEAS_FREE_HUM   = 16'h58E0;
  localparam logic [15:0] CMD_SOFT_RESET      = 16'h805D;
  localparam logic [15:0] CMD_READ_ID         = 16'hEFC8;

  // checksum
  localparam logic [7:0]  CRC_POLY            = 8'h31;
  localparam logic [7:0]  CRC_INIT            = 8'hFF;
  localparam logic [7:0]  CRC_FINAL_XOR       = 8'h00;

  // identity word layout: product code in the low bits
  localparam int          ID_CODE_LSB         = 0;
  localparam int          ID_CODE_W           = 6;
  localparam int          ID_FREE_LSB         = 6;
  localparam int          ID_FREE_W           = 10;

  // read sequences: byte, byte, crc (, byte, byte, crc)
  localparam logic [2:0]  LEN_MEAS            = 3'h6;
  localparam logic [2:0]  LEN_ID              = 3'h3;
  localparam logic [3:0]  BYTE_BITS           = 4'h8;

  // timing
  localparam real         CLK_PERIOD_NS       = 25.0;
  localparam real         MEAS_MAX_MS         = 14.4;
  localparam real         SOFT_RESET_MAX_US   = 230.0;
  localparam real         POWER_UP_MAX_US     = 239.0;
  localparam real         SDA_SETUP_NS        = 100.0;
  localparam int          MEAS_CYCLES  = int'($floor(MEAS_MAX_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int          SRST_CYCLES  = int'($floor(SOFT_RESET_MAX_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int          PWRUP_CYCLES = int'($floor(POWER_UP_MAX_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int          SETUP_CYCLES = int'($ceil(SDA_SETUP_NS / CLK_PERIOD_NS));
  localparam int          CNT_W               = 20;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'h0,
    BUS_RX   = 3'h1,
    BUS_ACK  = 3'h3,
    BUS_TXLD = 3'h2,
    BUS_TX   = 3'h6,
    BUS_MACK = 3'h7
  } hsc_bus_e;

  typedef enum logic [1:0] {
    MODE_PWRUP = 2'h0,
    MODE_IDLE  = 2'h1,
    MODE_MEAS  = 2'h3,
    MODE_SRST  = 2'h2
  } hsc_mode_e;

endpackage

// ### rtl/hsc_byte_buf.sv
`timescale 1ns/1ps
`default_nettype none
module hsc_byte_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } hsc_buf_s;

  hsc_buf_s q;
  hsc_buf_s n;
  logic     push;
  logic     pop;

  function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
    nextPtr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign inReady  = (q.cnt != CW'(DEPTH));
  assign outValid = (q.cnt != '0);
  assign outData  = q.mem[q.rd];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    n = q;
    if (flush) begin
      n.wr  = '0;
      n.rd  = '0;
      n.cnt = '0;
    end else begin
      if (push) begin
        n.mem[q.wr] = inData;
        n.wr        = nextPtr(q.wr);
      end
      if (pop) begin
        n.rd = nextPtr(q.rd);
      end
      if (push && !pop) begin
        n.cnt = CW'(q.cnt + 1'b1);
      end else if (pop && !push) begin
        n.cnt = CW'(q.cnt - 1'b1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule
`default_nettype wire

// ### rtl/hsc_i2c_target.sv
// Overview of operation
// - answer only target address 0x70
// - commands are 16 bits, high byte first
// - start opens; stop optional, restart accepted
// - after power-up delay, enter idle
// - fall back to low-energy idle unprompted
// - stretching: 0x7CA2 temp first, 0x5C24 hum
// - no stretching: 0x7866 temp, 0x58E0 hum
// - every measurement command measures both quantities
// - ack by SDA low in ninth clock
// - measurement starts at second command byte ack
// - free-running measurement: nack every header
// - stretching measurement: ack read, hold SCL
// - results: word, crc, word, crc, msb first
// - first word follows the command's order choice
// - next byte only after master ack
// - soft reset 0x805D only idle; clears flags, reloads cal
// - id command, then read gives id, crc
// - id bits 5:0 product code, rest free
// - crc-8 poly 0x31, init 0xFF, plain
// - crc covers the two preceding bytes
// - results are 16-bit compensated unsigned words
// - measurement completes within 14.4 ms
// - soft reset back to idle within 230 us
`timescale 1ns/1ps
`default_nettype none
module hsc_i2c_target #(
  parameter int              MEAS_CYCLES  = hsc_pkg::MEAS_CYCLES,
  parameter int              SRST_CYCLES  = hsc_pkg::SRST_CYCLES,
  parameter int              PWRUP_CYCLES = hsc_pkg::PWRUP_CYCLES,
  // value is arbitrary
  parameter logic [5:0]      PRODUCT_CODE = 6'h2A,
  parameter logic [9:0]      ID_FREE_BITS = 10'h155
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic [15:0] rawHumidityWord,
  input  wire logic [15:0] rawTemperatureWord,
  output logic             measStart,
  output logic             measBusy,
  output logic             calReload,
  output logic             lowPowerIdle
);

  localparam int CW = hsc_pkg::CNT_W;

  typedef struct packed {
    logic [2:0]       sclS;
    logic [2:0]       sdaS;
    hsc_pkg::hsc_bus_e  bus;
    hsc_pkg::hsc_mode_e mode;
    logic [CW-1:0]    cnt;
    logic [3:0]       bitCnt;
    logic [7:0]       shift;
    logic [2:0]       setupCnt;
    logic             hdr;
    logic             rdHdr;
    logic             cmdLo;
    logic             pendReset;
    logic [7:0]       cmdHi;
    logic             stretch;
    logic             humFirst;
    logic             resValid;
    logic             idPend;
    logic [15:0]      word0;
    logic [15:0]      word1;
    logic [2:0]       prodIdx;
    logic [2:0]       prodLen;
    logic             flush;
    logic             sdaOe;
    logic             sclOe;
    logic             measStart;
    logic             calReload;
    logic             lowPower;
    logic             measBusy;
  } hsc_top_s;

  hsc_top_s   q;
  hsc_top_s   n;
  logic       sclHigh;
  logic       sclRise;
  logic       sclFall;
  logic       startEv;
  logic       stopEv;
  logic       sdaNow;
  logic       bufInValid;
  logic       bufInReady;
  logic [7:0] bufInData;
  logic       bufOutValid;
  logic       bufOutReady;
  logic [7:0] bufOutData;
  logic       txPhase;

  // msb-first crc over one word
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = hsc_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ w[i]) begin
        c = {c[6:0], 1'b0} ^ hsc_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc8 = c ^ hsc_pkg::CRC_FINAL_XOR;
  endfunction

  function automatic logic [7:0] byteAt(input logic [2:0] idx, input logic [15:0] w0,
                                        input logic [15:0] w1);
    case (idx)
      3'h0:    byteAt = w0[15:8];
      3'h1:    byteAt = w0[7:0];
      3'h2:    byteAt = crc8(w0);
      3'h3:    byteAt = w1[15:8];
      3'h4:    byteAt = w1[7:0];
      3'h5:    byteAt = crc8(w1);
      default: byteAt = 8'h00;
    endcase
  endfunction

  // only the second and third stages are looked at
  assign sclHigh = q.sclS[1] & q.sclS[2];
  assign sclRise = q.sclS[1] & ~q.sclS[2];
  assign sclFall = ~q.sclS[1] & q.sclS[2];
  assign sdaNow  = q.sdaS[1];
  assign startEv = sclHigh & ~q.sdaS[1] & q.sdaS[2];
  assign stopEv  = sclHigh & q.sdaS[1] & ~q.sdaS[2];
  assign txPhase = (q.bus == hsc_pkg::BUS_TXLD) || (q.bus == hsc_pkg::BUS_TX) ||
                   (q.bus == hsc_pkg::BUS_MACK);

  // bytes are only produced once results exist, so a stretched read waits here
  assign bufInValid  = txPhase && (q.prodIdx < q.prodLen) &&
                       (q.mode != hsc_pkg::MODE_MEAS) && !q.flush;
  assign bufInData   = byteAt(q.prodIdx, q.word0, q.word1);
  assign bufOutReady = (q.bus == hsc_pkg::BUS_TXLD);

  hsc_byte_buf #(
    .WIDTH (8),
    .DEPTH (2)
  ) txBuf (
    .clk      (clk),
    .rst      (rst),
    .flush    (q.flush),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .inData   (bufInData),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );

  always_comb begin
    n           = q;
    n.sclS      = {q.sclS[1:0], sclIn};
    n.sdaS      = {q.sdaS[1:0], sdaIn};
    n.measStart = 1'b0;
    n.calReload = 1'b0;
    n.flush     = 1'b0;
    n.lowPower  = (q.mode == hsc_pkg::MODE_IDLE) && (q.bus == hsc_pkg::BUS_IDLE);

    case (q.mode)
      hsc_pkg::MODE_PWRUP: begin
        if (q.cnt >= CW'(PWRUP_CYCLES - 1)) begin
          n.mode = hsc_pkg::MODE_IDLE;
          n.cnt  = '0;
        end else begin
          n.cnt = CW'(q.cnt + 1'b1);
        end
      end
      hsc_pkg::MODE_MEAS: begin
        if (q.cnt >= CW'(MEAS_CYCLES - 1)) begin
          n.mode     = hsc_pkg::MODE_IDLE;
          n.cnt      = '0;
          n.resValid = 1'b1;
          // both quantities are always captured, order set by the command
          // converter words pass through untouched, already compensated
          n.word0    = q.humFirst ? rawHumidityWord : rawTemperatureWord;
          n.word1    = q.humFirst ? rawTemperatureWord : rawHumidityWord;
        end else begin
          n.cnt = CW'(q.cnt + 1'b1);
        end
      end
      hsc_pkg::MODE_SRST: begin
        if (q.cnt >= CW'(SRST_CYCLES - 1)) begin
          n.mode = hsc_pkg::MODE_IDLE;
          n.cnt  = '0;
        end else begin
          n.cnt = CW'(q.cnt + 1'b1);
        end
      end
      default: begin
        n.cnt = '0;
      end
    endcase

    if (q.mode == hsc_pkg::MODE_PWRUP || q.mode == hsc_pkg::MODE_SRST) begin
      n.bus   = hsc_pkg::BUS_IDLE;
      n.sdaOe = 1'b0;
      n.sclOe = 1'b0;
    end else if (startEv) begin
      n.bus     = hsc_pkg::BUS_RX;
      n.bitCnt  = '0;
      n.hdr     = 1'b1;
      n.cmdLo   = 1'b0;
      n.sdaOe   = 1'b0;
      n.sclOe   = 1'b0;
      n.flush   = 1'b1;
      n.prodIdx = '0;
      n.prodLen = '0;
    end else if (stopEv) begin
      n.bus     = hsc_pkg::BUS_IDLE;
      n.sdaOe   = 1'b0;
      n.sclOe   = 1'b0;
      n.flush   = 1'b1;
      n.prodLen = '0;
    end else begin
      case (q.bus)
        hsc_pkg::BUS_RX: begin
          if (sclRise) begin
            n.shift  = {q.shift[6:0], sdaNow};
            n.bitCnt = 4'(q.bitCnt + 1'b1);
          end else if (sclFall && q.bitCnt == hsc_pkg::BYTE_BITS) begin
            n.bus = hsc_pkg::BUS_IDLE;
            if (q.hdr) begin
              if (q.shift[7:1] == hsc_pkg::TARGET_ADDR) begin
                n.rdHdr = q.shift[0];
                if (q.shift[0]) begin
                  if ((q.mode == hsc_pkg::MODE_MEAS && q.stretch) ||
                      (q.mode == hsc_pkg::MODE_IDLE && (q.resValid || q.idPend))) begin
                    n.bus = hsc_pkg::BUS_ACK;
                  end
                end else if (q.mode == hsc_pkg::MODE_IDLE) begin
                  n.bus = hsc_pkg::BUS_ACK;
                end
              end
            end else if (!q.cmdLo) begin
              n.cmdHi = q.shift;
              n.bus   = hsc_pkg::BUS_ACK;
            end else begin
              n.bus = hsc_pkg::BUS_ACK;
              case ({q.cmdHi, q.shift})
                hsc_pkg::CMD_MEAS_STR_TEMP, hsc_pkg::CMD_MEAS_STR_HUM,
                hsc_pkg::CMD_MEAS_FREE_TEMP, hsc_pkg::CMD_MEAS_FREE_HUM: begin
                  n.mode      = hsc_pkg::MODE_MEAS;
                  n.cnt       = '0;
                  n.measStart = 1'b1;
                  n.stretch   = ({q.cmdHi, q.shift} == hsc_pkg::CMD_MEAS_STR_TEMP) ||
                                ({q.cmdHi, q.shift} == hsc_pkg::CMD_MEAS_STR_HUM);
                  n.humFirst  = ({q.cmdHi, q.shift} == hsc_pkg::CMD_MEAS_STR_HUM) ||
                                ({q.cmdHi, q.shift} == hsc_pkg::CMD_MEAS_FREE_HUM);
                  n.resValid  = 1'b0;
                  n.idPend    = 1'b0;
                end
                hsc_pkg::CMD_READ_ID: begin
                  n.idPend   = 1'b1;
                  n.resValid = 1'b0;
                  n.word0    = {ID_FREE_BITS, PRODUCT_CODE};
                end
                hsc_pkg::CMD_SOFT_RESET: begin
                  n.pendReset = 1'b1;
                end
                default: begin
                  n.bus = hsc_pkg::BUS_IDLE;
                end
              endcase
            end
            n.sdaOe = (n.bus == hsc_pkg::BUS_ACK);
          end
        end
        hsc_pkg::BUS_ACK: begin
          if (sclFall) begin
            n.sdaOe  = 1'b0;
            n.bitCnt = '0;
            if (q.hdr && q.rdHdr) begin
              n.bus     = hsc_pkg::BUS_TXLD;
              n.hdr     = 1'b0;
              n.prodIdx = '0;
              n.prodLen = q.idPend ? hsc_pkg::LEN_ID : hsc_pkg::LEN_MEAS;
            end else if (q.pendReset) begin
              // bus machine returns to idle, mode enters the soft-reset wait, flags clear and calibration reloads
              n.mode      = hsc_pkg::MODE_SRST;
              n.cnt       = '0;
              n.calReload = 1'b1;
              n.bus       = hsc_pkg::BUS_IDLE;
              n.pendReset = 1'b0;
              n.resValid  = 1'b0;
              n.idPend    = 1'b0;
              n.stretch   = 1'b0;
              n.humFirst  = 1'b0;
            end else if (q.hdr) begin
              n.bus   = hsc_pkg::BUS_RX;
              n.hdr   = 1'b0;
              n.cmdLo = 1'b0;
            end else if (!q.cmdLo) begin
              n.bus   = hsc_pkg::BUS_RX;
              n.cmdLo = 1'b1;
            end else begin
              n.bus = hsc_pkg::BUS_IDLE;
            end
          end
        end
        hsc_pkg::BUS_TXLD: begin
          if (bufOutValid) begin
            n.shift    = bufOutData;
            n.sdaOe    = ~bufOutData[7];
            n.bitCnt   = 4'h1;
            n.setupCnt = 3'(hsc_pkg::SETUP_CYCLES);
            n.bus      = hsc_pkg::BUS_TX;
          end else if (q.prodIdx == q.prodLen) begin
            n.sclOe = 1'b0;
            n.bus   = hsc_pkg::BUS_IDLE;
          end else begin
            // no byte yet: hold the clock low until one arrives
            n.sclOe = 1'b1;
          end
        end
        hsc_pkg::BUS_TX: begin
          // sda settles before scl is let go after a stretch
          if (q.setupCnt != '0) begin
            n.setupCnt = 3'(q.setupCnt - 1'b1);
          end else begin
            n.sclOe = 1'b0;
          end
          if (sclFall) begin
            if (q.bitCnt == hsc_pkg::BYTE_BITS) begin
              n.sdaOe = 1'b0;
              n.bus   = hsc_pkg::BUS_MACK;
            end else begin
              n.sdaOe  = ~q.shift[6];
              n.shift  = {q.shift[6:0], 1'b0};
              n.bitCnt = 4'(q.bitCnt + 1'b1);
            end
          end
        end
        hsc_pkg::BUS_MACK: begin
          if (sclRise && sdaNow) begin
            n.bus     = hsc_pkg::BUS_IDLE;
            n.flush   = 1'b1;
            n.prodLen = '0;
          end else if (sclFall) begin
            n.bus = hsc_pkg::BUS_TXLD;
          end
        end
        default: begin
          n.sdaOe = 1'b0;
          n.sclOe = 1'b0;
        end
      endcase
    end

    if (bufInValid && bufInReady) begin
      n.prodIdx = 3'(q.prodIdx + 1'b1);
    end
    n.measBusy = (n.mode == hsc_pkg::MODE_MEAS);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // open-drain pins only ever pull low
  assign sclOut       = 1'b0;
  assign sdaOut       = 1'b0;
  assign sclOe        = q.sclOe;
  assign sdaOe        = q.sdaOe;
  assign measStart    = q.measStart;
  assign calReload    = q.calReload;
  assign lowPowerIdle = q.lowPower;
  assign measBusy     = q.measBusy;

endmodule
`default_nettype wire

// ### tb/hsc_i2c_target_chk.sv
`timescale 1ns/1ps
`default_nettype none
module hsc_i2c_target_chk #(
  parameter int MEAS_CYCLES  = 200,
  parameter int SRST_CYCLES  = 20,
  parameter int PWRUP_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic measStart,
  input wire logic measBusy,
  input wire logic calReload,
  input wire logic lowPowerIdle
);
  int busyCnt_q;
  int pwrCnt_q;
  int srstCnt_q;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // counters saturate or clear so that long runs never wrap
  always_ff @(posedge clk) begin
    if (rst) begin
      busyCnt_q <= 0;
      pwrCnt_q  <= 0;
      srstCnt_q <= 0;
    end else begin
      busyCnt_q <= measBusy ? busyCnt_q + 1 : 0;
      pwrCnt_q  <= (pwrCnt_q > PWRUP_CYCLES) ? pwrCnt_q : pwrCnt_q + 1;
      srstCnt_q <= calReload ? 1 : ((srstCnt_q != 0 && !lowPowerIdle) ? srstCnt_q + 1 : 0);
    end
  end

  property p_rst_clear; $fell(rst) |-> !sdaOe && !sclOe && !measStart && !calReload; endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs active after reset");
  property p_pwrup; pwrCnt_q < PWRUP_CYCLES |-> !sdaOe && !measBusy && !lowPowerIdle; endproperty
  a_pwrup: assert property (p_pwrup) else $error("bus answered during power-up");
  property p_start_busy; measStart |-> ##[0:1] measBusy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
  property p_busy_bound; busyCnt_q <= MEAS_CYCLES + 1; endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("measurement too long");
  property p_busy_len; $fell(measBusy) |-> busyCnt_q >= MEAS_CYCLES - 1; endproperty
  a_busy_len: assert property (p_busy_len) else $error("measurement cut short");
  property p_idle_quiet; lowPowerIdle |-> !measBusy && !sclOe && !sdaOe; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle while active");
  property p_srst_idle; calReload |-> !measBusy && !$past(measBusy); endproperty
  a_srst_idle: assert property (p_srst_idle) else $error("reset during measurement");
  property p_srst_back; srstCnt_q <= SRST_CYCLES + 40; endproperty
  a_srst_back: assert property (p_srst_back) else $error("soft reset too slow");
  property p_sda_on_low; $changed(sdaOe) |-> !sclIn; endproperty
  a_sda_on_low: assert property (p_sda_on_low) else $error("data moved with clock high");

  c_meas: cover property (measStart);
  c_reload: cover property (calReload);
  c_stretch: cover property (sclOe && measBusy);
endmodule

bind hsc_i2c_target hsc_i2c_target_chk #(
  .MEAS_CYCLES(MEAS_CYCLES),
  .SRST_CYCLES(SRST_CYCLES),
  .PWRUP_CYCLES(PWRUP_CYCLES)
) i_hsc_i2c_target_chk (
  .clk, .rst, .sclIn, .sclOe, .sdaOe, .measStart, .measBusy, .calReload, .lowPowerIdle
);
`default_nettype wire

// ### tb/hsc_mst.sv
`timescale 1ns/1ps
`default_nettype none
module hsc_mst (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output var logic  sclLow,
  output var logic  sdaLow
);
  // open drain: only pulls low, pull-ups make the high level
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // bounded wait, the target may hold the clock low
  task automatic relScl();
    sclLow = 1'b0;
    for (int k = 0; k < 4000 && scl !== 1'b1; k++) tick(1);
  endtask

  // one clock of 200 ns: 5 cycles low, 3 high
  task automatic bitx(input logic b, output logic r);
    tick(1);
    sdaLow = !b;
    tick(4);
    relScl();
    tick(1);
    r = sda;
    tick(1);
    sclLow = 1'b1;
  endtask

  task automatic start();
    tick(1);
    sdaLow = 1'b0;
    tick(3);
    relScl();
    tick(2);
    sdaLow = 1'b1;
    tick(3);
    sclLow = 1'b1;
  endtask

  task automatic stop();
    tick(1);
    sdaLow = 1'b1;
    tick(3);
    relScl();
    tick(2);
    sdaLow = 1'b0;
    tick(3);
  endtask

  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask

  task automatic recvByte(output logic [7:0] d, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int         MEAS   = 200;
  localparam int         SRST   = 20;
  localparam int         PWR    = 20;
  localparam logic [5:0] PCODE  = 6'h1B;
  localparam logic [9:0] IDFREE = 10'h2D3;
  localparam logic [7:0] BAD [3] = '{8'hE2, 8'h60, 8'hF1};
  localparam logic [15:0] CMDS [4] = '{16'h7CA2, 16'h5C24, 16'h7866, 16'h58E0};

  logic        clk;
  logic        rst;
  logic [15:0] hum;
  logic [15:0] tmp;
  logic [7:0]  rb [6];
  int          errTotal = 0;
  int          testsRun = 0;
  int          nStart = 0;
  int          nReload = 0;
  wire logic   sclOe, sdaOe, sclLow, sdaLow, measStart, calReload, lowPowerIdle, measBusy;
  wire logic   scl = !(sclOe | sclLow);
  wire logic   sda = !(sdaOe | sdaLow);

  hsc_i2c_target #(.MEAS_CYCLES(MEAS), .SRST_CYCLES(SRST), .PWRUP_CYCLES(PWR),
    .PRODUCT_CODE(PCODE), .ID_FREE_BITS(IDFREE)) i_hsc_i2c_target (
    .clk(clk), .rst(rst), .sclIn(scl), .sclOut(), .sclOe(sclOe), .sdaIn(sda), .sdaOut(),
    .sdaOe(sdaOe), .rawHumidityWord(hum), .rawTemperatureWord(tmp), .measStart(measStart),
    .measBusy(measBusy), .calReload(calReload), .lowPowerIdle(lowPowerIdle));
  hsc_mst i_hsc_mst (.clk(clk), .scl(scl), .sda(sda), .sclLow(sclLow), .sdaLow(sdaLow));

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (measStart === 1'b1) nStart++;
    if (calReload === 1'b1) nReload++;
  end

  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrCmd(input logic [15:0] c, output logic [2:0] a);
    i_hsc_mst.start();
    i_hsc_mst.sendByte({7'h70, 1'b0}, a[2]);
    i_hsc_mst.sendByte(c[15:8], a[1]);
    i_hsc_mst.sendByte(c[7:0], a[0]);
  endtask

  task automatic rdHdr(output logic k);
    i_hsc_mst.start();
    i_hsc_mst.sendByte({7'h70, 1'b1}, k);
  endtask

  task automatic rd(input int n);
    for (int i = 0; i < n; i++) i_hsc_mst.recvByte(rb[i], i == n - 1);
  endtask

  task automatic scPwr();
    logic k;
    i_hsc_mst.start();
    i_hsc_mst.sendByte(8'hE0, k);
    chk(16'(k), 16'h0);
    i_hsc_mst.stop();
    repeat (PWR + 10) @(negedge clk);
    chk(16'(lowPowerIdle), 16'h1);
  endtask

  task automatic scAddr();
    logic k;
    for (int i = 0; i < 3; i++) begin
      i_hsc_mst.start();
      i_hsc_mst.sendByte(BAD[i], k);
      chk(16'(k), 16'h0);
      i_hsc_mst.stop();
    end
  endtask

  task automatic scId();
    logic [2:0]  a;
    logic        k;
    logic [15:0] w;
    w = {IDFREE, PCODE};
    wrCmd(hsc_pkg::CMD_READ_ID, a);
    chk(16'(a), 16'h7);
    rdHdr(k);
    chk(16'(k), 16'h1);
    rd(3);
    chk({rb[0], rb[1]}, w);
    chk(16'(rb[2]), 16'(crc8(w)));
    i_hsc_mst.stop();
  endtask

  task automatic scMeas(input int idx);
    logic [2:0]  a;
    logic        k;
    int          s0;
    logic [15:0] w0;
    logic [15:0] w1;
    hum = 16'hA5C3 + 16'(idx);
    tmp = 16'h3C5A ^ 16'(idx << 4);
    s0 = nStart;
    wrCmd(CMDS[idx], a);
    chk(16'(a), 16'h7);
    i_hsc_mst.stop();
    chk(16'(nStart - s0), 16'h1);
    chk(16'(measBusy), 16'h1);
    rdHdr(k);
    chk(16'(k), 16'(idx < 2));
    for (int n = 0; n < 40 && k !== 1'b1; n++) begin
      i_hsc_mst.stop();
      // a 20-cycle gap separates the polls while converting
      repeat (20) @(negedge clk);
      rdHdr(k);
    end
    chk(16'(k), 16'h1);
    rd(6);
    w0 = (idx % 2 == 0) ? tmp : hum;
    w1 = (idx % 2 == 0) ? hum : tmp;
    chk({rb[0], rb[1]}, w0);
    chk(16'(rb[2]), 16'(crc8(w0)));
    chk({rb[3], rb[4]}, w1);
    chk(16'(rb[5]), 16'(crc8(w1)));
    i_hsc_mst.stop();
  endtask

  task automatic scAbort();
    logic k;
    rdHdr(k);
    chk(16'(k), 16'h1);
    i_hsc_mst.recvByte(rb[0], 1'b1);
    chk(16'(rb[0]), 16'(hum[15:8]));
    repeat (6) @(negedge clk);
    chk(16'(sdaOe), 16'h0);
    i_hsc_mst.stop();
  endtask

  task automatic scUnknown();
    logic [2:0] a;
    wrCmd(16'h1234, a);
    chk(16'(a), 16'h6);
    i_hsc_mst.stop();
  endtask

  task automatic scSrst();
    logic [2:0] a;
    logic       k;
    int         r0;
    r0 = nReload;
    wrCmd(hsc_pkg::CMD_SOFT_RESET, a);
    chk(16'(a), 16'h7);
    i_hsc_mst.stop();
    chk(16'(nReload - r0), 16'h1);
    repeat (SRST + 10) @(negedge clk);
    chk(16'(lowPowerIdle), 16'h1);
    rdHdr(k);
    chk(16'(k), 16'h0);
    i_hsc_mst.stop();
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    hum = 16'h0000;
    tmp = 16'h0000;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    scPwr();
    scAddr();
    scId();
    for (int i = 0; i < 4; i++) scMeas(i);
    scAbort();
    scUnknown();
    scSrst();
    summarize();
  end

  // whole run is well under 10000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    errTotal++;
    summarize();
  end
endmodule
`default_nettype wire
